// file: rtl/vmx_field_exit_unit.sv
// Host natural-width field decoder and store, plus exit-reason recorder,
// behind an AXI4-Lite slave.
// Assumes core events are synchronous to mclk and one cycle wide.
//
// The register offsets and register access over AXI4-Lite were decided locally.
`timescale 1ns/10ps
`include "vmx_coder_consts.svh"

// How it works
// R1 - Encoding bits 11:10 equal to 3 mark the host-state area.
// R2 - Encoding bits 9:1 give the field index within the host group.
// R3 - Indices 0 to 7 select the control and base fields from 6C00H.
// R4 - Indices 8 to 11 select syscall pointers, stack and instruction pointer.
// R5 - Indices 12 to 14 exist only when shadow-stack load is supported.
// R6 - Each exit stores a 32-bit exit-reason value.
// R7 - An entry failure stores its reason in the same field.
// R8 - The basic reason sits in the low 16 bits of that value.
// R9 - Reason 0 for bitmap-hit exceptions or exiting non-maskable interrupts.
// R10 - Reason 0 also covers bound, trap, overflow and undefined-opcode faults.
// R11 - Reason 1 for external interrupts with their exiting control set.
// R12 - Reason 2 for unintercepted exceptions while calling double-fault.
// R13 - Reason 3 when the initialization signal arrives.
// R14 - Reason 4 for a startup interrupt while waiting for one.
// R15 - Reason 5 for a management interrupt right after an I/O retire.
// R16 - Reason 6 for any other management interrupt exit.
// R17 - Reason 7 at a boundary: flag set, unblocked, window control set.
// R18 - Reason 8 at a boundary: no virtual blocking, no load block, control.
// R19 - Reason 9 when guest software attempts a task switch.
// R20 - Encoding bits 14:13 equal to 3 mark a natural-width field.
// R21 - Natural-width fields need bit 0 clear, full access only.
// R22 - Indices past the list, or absent shadow fields, are unsupported.
module vmx_field_exit_unit #(
  parameter int NAT_W = 64
) (
  input  wire logic                        mclk,
  input  wire logic                        nrst,
  input  wire logic                        ce,
  // AXI4-Lite slave.
  input  wire logic [7:0]                  s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [7:0]                  s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  // Core events.
  input  wire logic                        exception_event,
  input  wire logic [4:0]                  exception_vector,
  input  wire logic                        in_double_fault_call,
  input  wire logic                        nmi_event,
  input  wire logic                        ext_int_event,
  input  wire logic                        init_event,
  input  wire logic                        startup_ipi_event,
  input  wire logic                        wait_for_startup_ipi,
  input  wire logic                        mgmt_event,
  input  wire logic                        io_just_retired,
  input  wire logic                        instr_boundary,
  input  wire logic                        interrupt_flag,
  input  wire logic                        blocked_by_int_en,
  input  wire logic                        blocked_by_ss_load,
  input  wire logic                        virtual_nmi_blocked,
  input  wire logic                        task_switch_event,
  input  wire logic                        entry_fail_event,
  input  wire logic [15:0]                 entry_fail_reason,
  // Exit report and field decode result.
  output logic                             exit_valid,
  output logic [31:0]                      exit_reason,
  output vmx_coder_pkg::host_field_t       selected_field,
  output logic                             field_supported
);
  import vmx_coder_pkg::*;

  if (NAT_W < 33 || NAT_W > 64) begin : g_width_check
    $error("NAT_W must lie between 33 and 64");
  end

  localparam int NF = `HOST_FIELD_COUNT;

  // ---------------------------------------------------------------
  // Software-visible state, and the exit_valid pulse register.
  logic [`CTL_WIDTH-1:0] controls_q;
  logic [31:0]           bitmap_q;
  logic [15:0]           select_q;
  logic [31:0]           reason_q;
  logic                  new_exit_q;
  logic                  entry_fail_q;
  logic [15:0]           count_q;
  logic                  exit_valid_q;
  logic [NAT_W-1:0]      field_q [NF];

  // ---------------------------------------------------------------
  // Field encoding decode.
  wire [1:0] enc_area  = select_q[`ENC_AREA_HI:`ENC_AREA_LO];
  wire [1:0] enc_width = select_q[`ENC_WIDTH_HI:`ENC_WIDTH_LO];
  wire [8:0] enc_index = select_q[`ENC_INDEX_HI:`ENC_INDEX_LO];
  wire       is_host   = enc_area == `ENC_AREA_HOST;            // [R1]
  wire       is_nat    = enc_width == `ENC_WIDTH_NATURAL;       // [R20]
  wire       is_full   = ~select_q[`ENC_ACCESS_BIT];            // [R21]
  wire       ss_sup    = controls_q[`CTL_SS_LOAD_SUP];
  // Basic fields run contiguously up from the group base.
  wire       in_basic  = enc_index <= `HOST_LAST_BASIC;         // [R3] [R4]
  // Shadow-stack fields follow and exist only with load support.
  wire       in_shadow = ss_sup & (enc_index <= `HOST_LAST_SHADOW); // [R5]
  wire       supported = is_host & is_nat & is_full &
                         (in_basic | in_shadow);                // [R22]
  wire [3:0] slot      = enc_index[3:0];                        // [R2]

  assign selected_field  = host_field_t'(supported ? slot : 4'h0);
  assign field_supported = supported;

  wire [31:0] decode_word = {19'h0, enc_index, supported, is_full,
                             is_nat, is_host};

  wire [63:0] sel_field = supported ? 64'(field_q[slot]) : 64'h0;

  // ---------------------------------------------------------------
  // AXI write channel: address and data are taken in either order.
  logic       aw_full_q;
  logic       w_full_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic       bvalid_q;
  logic [1:0] bresp_q;

  assign s_axi_awready = ~aw_full_q & ~bvalid_q;
  assign s_axi_wready  = ~w_full_q & ~bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;

  wire aw_take  = s_axi_awvalid & s_axi_awready;
  wire w_take   = s_axi_wvalid & s_axi_wready;
  wire do_write = aw_full_q & w_full_q & ~bvalid_q;

  wire wr_ctl  = do_write & (aw_addr_q == `OFS_CONTROLS);
  wire wr_bmp  = do_write & (aw_addr_q == `OFS_EXC_BITMAP);
  wire wr_sel  = do_write & (aw_addr_q == `OFS_FIELD_SELECT);
  wire wr_lo   = do_write & (aw_addr_q == `OFS_FIELD_LOW);
  wire wr_hi   = do_write & (aw_addr_q == `OFS_FIELD_HIGH);
  wire wr_est  = do_write & (aw_addr_q == `OFS_EXIT_STATUS);
  wire wr_ro   = do_write & ((aw_addr_q == `OFS_DECODE_STATUS) |
                             (aw_addr_q == `OFS_EXIT_REASON));
  wire wr_ok   = wr_ctl | wr_bmp | wr_sel | wr_lo | wr_hi | wr_est | wr_ro;

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction

  wire [31:0] ctl_m = merge({27'h0, controls_q}, w_data_q, w_strb_q);
  wire [31:0] bmp_m = merge(bitmap_q, w_data_q, w_strb_q);
  wire [31:0] sel_m = merge({16'h0, select_q}, w_data_q, w_strb_q);
  wire [31:0] lo_m  = merge(sel_field[31:0], w_data_q, w_strb_q);
  wire [31:0] hi_m  = merge(sel_field[63:32], w_data_q, w_strb_q);
  wire [63:0] fld_m = wr_lo ? {sel_field[63:32], lo_m} :
                              {hi_m, sel_field[31:0]};
  wire        est_clr = wr_est & w_strb_q[0] & w_data_q[`EST_NEW_EXIT];

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `RESP_OKAY;
    end else if (ce) begin
      if (aw_take) begin
        aw_full_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        w_full_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_full_q <= 1'b0;
        w_full_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      controls_q <= `CTL_RESET;
      bitmap_q   <= `BITMAP_RESET;
      select_q   <= `SELECT_RESET;
    end else if (ce) begin
      if (wr_ctl) begin
        controls_q <= ctl_m[`CTL_WIDTH-1:0];
      end
      if (wr_bmp) begin
        bitmap_q <= bmp_m;
      end
      if (wr_sel) begin
        select_q <= sel_m[15:0];
      end
    end
  end

  // Host field store: a write to an unsupported encoding is dropped.
  for (genvar i = 0; i < NF; i++) begin : g_field
    wire hit_i = (wr_lo | wr_hi) & supported & (slot == 4'(i)); // [R22]
    always_ff @(posedge mclk) begin
      if (!nrst) begin
        field_q[i] <= '0;
      end else if (ce && hit_i) begin
        field_q[i] <= fld_m[NAT_W-1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // AXI read channel: one cycle from address to data.
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;

  assign s_axi_arready = ~rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  wire ar_take = s_axi_arvalid & s_axi_arready;

  wire [31:0] status_word = {count_q, 14'h0, entry_fail_q, new_exit_q};

  logic [31:0] rd_mux;
  logic        rd_ok;
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_ok  = 1'b1;
    unique case (s_axi_araddr)
      `OFS_CONTROLS:      rd_mux = {27'h0, controls_q};
      `OFS_EXC_BITMAP:    rd_mux = bitmap_q;
      `OFS_FIELD_SELECT:  rd_mux = {16'h0, select_q};
      `OFS_DECODE_STATUS: rd_mux = decode_word;
      `OFS_FIELD_LOW:     rd_mux = sel_field[31:0];
      `OFS_FIELD_HIGH:    rd_mux = sel_field[63:32];
      `OFS_EXIT_REASON:   rd_mux = reason_q;
      `OFS_EXIT_STATUS:   rd_mux = status_word;
      default:            rd_ok  = 1'b0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= `RESP_OKAY;
    end else if (ce) begin
      if (ar_take) begin
        rvalid_q <= 1'b1;
        rdata_q  <= rd_mux;
        rresp_q  <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (rvalid_q && s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Exit cause coding and recording.
  logic          cause_hit;
  basic_reason_t cause_reason;

  exit_reason_coder u_coder (
    .exception_event      (exception_event),
    .exception_vector     (exception_vector),
    .in_double_fault_call (in_double_fault_call),
    .exception_bitmap     (bitmap_q),
    .nmi_event            (nmi_event),
    .ext_int_event        (ext_int_event),
    .init_event           (init_event),
    .startup_ipi_event    (startup_ipi_event),
    .wait_for_startup_ipi (wait_for_startup_ipi),
    .mgmt_event           (mgmt_event),
    .io_just_retired      (io_just_retired),
    .instr_boundary       (instr_boundary),
    .interrupt_flag       (interrupt_flag),
    .blocked_by_int_en    (blocked_by_int_en),
    .blocked_by_ss_load   (blocked_by_ss_load),
    .virtual_nmi_blocked  (virtual_nmi_blocked),
    .task_switch_event    (task_switch_event),
    .controls             (controls_q),
    .hit                  (cause_hit),
    .reason               (cause_reason)
  );

  // An entry failure excludes an exit in the same cycle, so it wins.
  wire        record  = entry_fail_event | cause_hit;           // [R6] [R7]
  wire [15:0] basic   = entry_fail_event ? entry_fail_reason :
                                           16'(cause_reason);
  wire [31:0] reason_d = {16'h0, basic};                        // [R8]

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      reason_q     <= `REASON_RESET;
      new_exit_q   <= 1'b0;
      entry_fail_q <= 1'b0;
      count_q      <= 16'h0000;
      exit_valid_q <= 1'b0;
    end else if (ce) begin
      exit_valid_q <= record;
      if (record) begin
        reason_q     <= reason_d;                               // [R6]
        entry_fail_q <= entry_fail_event;                       // [R7]
        count_q      <= 16'(count_q + 16'h0001);
      end
      // A new record in the clearing cycle keeps the flag set.
      if (record) begin
        new_exit_q <= 1'b1;
      end else if (est_clr) begin
        new_exit_q <= 1'b0;
      end
    end
  end

  assign exit_valid  = exit_valid_q;
  assign exit_reason = reason_q;

endmodule

// file: inc/vmx_coder_consts.svh
// Offsets, field positions, reset values and encodings for the host field
// decoder and exit-reason coder. Assumes inclusion by bare name.
`ifndef VMX_CODER_CONSTS_SVH
`define VMX_CODER_CONSTS_SVH

// Register byte offsets on the AXI4-Lite slave.
`define OFS_CONTROLS      8'h00
`define OFS_EXC_BITMAP    8'h04
`define OFS_FIELD_SELECT  8'h08
`define OFS_DECODE_STATUS 8'h0C
`define OFS_FIELD_LOW     8'h10
`define OFS_FIELD_HIGH    8'h14
`define OFS_EXIT_REASON   8'h18
`define OFS_EXIT_STATUS   8'h1C

// Bits of the controls register.
`define CTL_NMI_EXITING   0
`define CTL_EXT_EXITING   1
`define CTL_IWIN_EXITING  2
`define CTL_NWIN_EXITING  3
`define CTL_SS_LOAD_SUP   4
`define CTL_WIDTH         5
`define CTL_RESET         5'h00

// Bits of the decode status register.
`define DEC_HOST_AREA     0
`define DEC_NATURAL       1
`define DEC_FULL_ACCESS   2
`define DEC_SUPPORTED     3
`define DEC_INDEX_LO      4
`define DEC_INDEX_HI      12

// Bits of the exit status register.
`define EST_NEW_EXIT      0
`define EST_ENTRY_FAIL    1
`define EST_COUNT_LO      16
`define EST_COUNT_HI      31

// Field encoding layout.
`define ENC_AREA_HI       11
`define ENC_AREA_LO       10
`define ENC_WIDTH_HI      14
`define ENC_WIDTH_LO      13
`define ENC_INDEX_HI      9
`define ENC_INDEX_LO      1
`define ENC_ACCESS_BIT    0
`define ENC_AREA_HOST     2'h3
`define ENC_WIDTH_NATURAL 2'h3
`define ENC_HOST_NAT_BASE 16'h6C00
`define HOST_LAST_BASIC   9'h00B
`define HOST_LAST_SHADOW  9'h00E
`define HOST_FIELD_COUNT  15

// Reset values.
`define BITMAP_RESET      32'h0000_0000
`define SELECT_RESET      16'h6C00
`define REASON_RESET      32'h0000_0000

// AXI response codes.
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`endif

// file: inc/vmx_coder_pkg.sv
// Types for the host field decoder and exit-reason coder.
// Assumes nothing of its surroundings.
package vmx_coder_pkg;

  typedef enum logic [15:0] {
    reason_exception_or_nmi = 16'h0000,
    reason_external_int     = 16'h0001,
    reason_triple_fault     = 16'h0002,
    reason_init_signal      = 16'h0003,
    reason_startup_ipi      = 16'h0004,
    reason_io_mgmt          = 16'h0005,
    reason_other_mgmt       = 16'h0006,
    reason_interrupt_window = 16'h0007,
    reason_nmi_window       = 16'h0008,
    reason_task_switch      = 16'h0009
  } basic_reason_t;

  typedef enum logic [3:0] {
    fld_control_register_zero               = 4'h0,
    fld_page_table_root_register            = 4'h1,
    fld_control_register_four               = 4'h2,
    fld_fs_base                             = 4'h3,
    fld_gs_base                             = 4'h4,
    fld_task_register_base                  = 4'h5,
    fld_global_descriptor_table_base        = 4'h6,
    fld_interrupt_descriptor_table_base     = 4'h7,
    fld_fast_syscall_stack_pointer          = 4'h8,
    fld_fast_syscall_entry_pointer          = 4'h9,
    fld_stack_pointer                       = 4'hA,
    fld_instruction_pointer                 = 4'hB,
    fld_supervisor_shadow_stack_control     = 4'hC,
    fld_shadow_stack_pointer                = 4'hD,
    fld_interrupt_shadow_stack_table_address = 4'hE
  } host_field_t;

endpackage

// file: rtl/exit_reason_coder.sv
// Combinational cause-to-reason coder for basic exit reasons 0 to 9.
// Assumes event inputs are one-cycle pulses on the core clock.
`timescale 1ns/10ps
`include "vmx_coder_consts.svh"
module exit_reason_coder (
  input  wire logic                        exception_event,
  input  wire logic [4:0]                  exception_vector,
  input  wire logic                        in_double_fault_call,
  input  wire logic [31:0]                 exception_bitmap,
  input  wire logic                        nmi_event,
  input  wire logic                        ext_int_event,
  input  wire logic                        init_event,
  input  wire logic                        startup_ipi_event,
  input  wire logic                        wait_for_startup_ipi,
  input  wire logic                        mgmt_event,
  input  wire logic                        io_just_retired,
  input  wire logic                        instr_boundary,
  input  wire logic                        interrupt_flag,
  input  wire logic                        blocked_by_int_en,
  input  wire logic                        blocked_by_ss_load,
  input  wire logic                        virtual_nmi_blocked,
  input  wire logic                        task_switch_event,
  input  wire logic [`CTL_WIDTH-1:0]       controls,
  output logic                             hit,
  output vmx_coder_pkg::basic_reason_t     reason
);
  import vmx_coder_pkg::*;

  wire bitmap_hit  = exception_bitmap[exception_vector];
  // An exception while calling the double-fault handler, not intercepted.
  wire c_triple    = exception_event & in_double_fault_call & ~bitmap_hit;
  // Trap, bound, overflow and undefined-opcode faults arrive here as well.
  wire c_exc       = exception_event & bitmap_hit;
  wire c_nmi       = nmi_event & controls[`CTL_NMI_EXITING];
  wire c_ext       = ext_int_event & controls[`CTL_EXT_EXITING];
  wire c_init      = init_event;
  wire c_wake      = startup_ipi_event & wait_for_startup_ipi;
  wire c_io_mgmt   = mgmt_event & io_just_retired;
  wire c_oth_mgmt  = mgmt_event & ~io_just_retired;
  wire c_iwin      = instr_boundary & interrupt_flag & ~blocked_by_int_en &
                     ~blocked_by_ss_load & controls[`CTL_IWIN_EXITING];
  wire c_nwin      = instr_boundary & ~virtual_nmi_blocked &
                     ~blocked_by_ss_load & controls[`CTL_NWIN_EXITING];
  wire c_task      = task_switch_event;

  assign hit = c_triple | c_exc | c_nmi | c_ext | c_init | c_wake |
               c_io_mgmt | c_oth_mgmt | c_iwin | c_nwin | c_task;

  // Fixed priority: the most severe cause wins when several coincide.
  assign reason = c_triple  ? reason_triple_fault     :     // [R12]
                  c_init    ? reason_init_signal      :     // [R13]
                  c_wake    ? reason_startup_ipi      :     // [R14]
                  c_io_mgmt ? reason_io_mgmt          :     // [R15]
                  c_oth_mgmt ? reason_other_mgmt      :     // [R16]
                  (c_exc | c_nmi) ? reason_exception_or_nmi : // [R9] [R10]
                  c_ext     ? reason_external_int     :     // [R11]
                  c_nwin    ? reason_nmi_window       :     // [R18]
                  c_iwin    ? reason_interrupt_window :     // [R17]
                  reason_task_switch;                       // [R19]

endmodule

// file: bench/vmx_field_exit_unit_properties.sv
// Concurrent checks on the exit recorder and field decoder ports.
// Assumes ce is held high while causes are offered.
`timescale 1ns/10ps
module vmx_field_exit_unit_properties (
  input wire logic mclk, nrst, ce, exit_valid, field_supported,
  input wire logic [31:0] exit_reason,
  input wire vmx_coder_pkg::host_field_t selected_field,
  input wire logic entry_fail_event, exception_event, in_double_fault_call,
  input wire logic init_event, startup_ipi_event, wait_for_startup_ipi,
  input wire logic mgmt_event, io_just_retired, nmi_event, ext_int_event,
  input wire logic instr_boundary, task_switch_event,
  input wire logic [15:0] entry_fail_reason
);
  import vmx_coder_pkg::*;
  wire hp = entry_fail_event | (exception_event & in_double_fault_call);
  wire sp = startup_ipi_event & wait_for_startup_ipi;
  wire np = !(hp | exception_event | nmi_event | ext_int_event | init_event
    | startup_ipi_event | mgmt_event | instr_boundary);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  property p_entry;
    ce && entry_fail_event |=>
      exit_reason == {16'h0000, $past(entry_fail_reason)};
  endproperty
  a_entry: assert property (p_entry) else $error("entry reason");
  property p_init;
    ce && init_event && !hp |-> ##1 exit_valid && exit_reason == 32'h3;
  endproperty
  a_init: assert property (p_init) else $error("init reason");
  property p_wake;
    ce && sp && !init_event && !hp |=> exit_reason == 32'h4;
  endproperty
  a_wake: assert property (p_wake) else $error("wake reason");
  property p_mgmt;
    ce && mgmt_event && !sp && !init_event && !hp |=>
      exit_reason == ($past(io_just_retired) ? 32'h5 : 32'h6);
  endproperty
  a_mgmt: assert property (p_mgmt) else $error("mgmt reason");
  property p_task;
    ce && task_switch_event && np |=> exit_valid && exit_reason == 32'h9;
  endproperty
  a_task: assert property (p_task) else $error("task reason");
  property p_quiet;
    ce && np && !task_switch_event |=> !exit_valid;
  endproperty
  a_quiet: assert property (p_quiet) else $error("exit no cause");
  property p_upper;
    exit_valid |-> exit_reason[31:16] == 16'h0000;
  endproperty
  a_upper: assert property (p_upper) else $error("upper bits");
  property p_unsup;
    !field_supported |-> selected_field == 4'h0;
  endproperty
  a_unsup: assert property (p_unsup) else $error("unsup field");
  c_task: cover property (exit_valid && exit_reason == 32'h9);
  c_shadow: cover property (field_supported && selected_field == 4'hE);
  c_entry: cover property (ce && entry_fail_event);
endmodule
bind vmx_field_exit_unit vmx_field_exit_unit_properties u_props (.*);

// file: bench/tb.sv
// Self-checking bench for the host field decoder and exit recorder.
// Assumes the package and constants header are compiled first.
`timescale 1ns/10ps
`include "vmx_coder_consts.svh"
module tb;
  import vmx_coder_pkg::*;
  logic mclk, nrst, ce, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, exit_valid;
  logic field_supported, s, lf;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, exit_reason, bm, rv, xd, last;
  logic [3:0] s_axi_wstrb, ctl;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic [15:0] e, nf;
  logic [8:0] p, pn;
  logic [6:0] l, nl;
  logic [4:0] nv;
  host_field_t selected_field;
  int bad_count, n_compared, x, nr;
  vmx_field_exit_unit DUT (.*, .exception_vector(nv), .entry_fail_reason(nf),
    .entry_fail_event(p[0]), .exception_event(p[1]), .nmi_event(p[2]),
    .ext_int_event(p[3]), .init_event(p[4]), .startup_ipi_event(p[5]),
    .mgmt_event(p[6]), .instr_boundary(p[7]), .task_switch_event(p[8]),
    .in_double_fault_call(l[0]), .wait_for_startup_ipi(l[1]),
    .io_just_retired(l[2]), .interrupt_flag(l[3]), .blocked_by_int_en(l[4]),
    .blocked_by_ss_load(l[5]), .virtual_nmi_blocked(l[6]));
  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] w);
    n_compared++;
    if (g !== w) begin
      bad_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, w);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tk;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge mclk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tk = s_axi_bvalid;
      rr = s_axi_bresp;
      @(posedge mclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tk) s_axi_bready <= 1'b0;
    end while (!tk);
  endtask
  task automatic rd(input logic [7:0] a);
    logic ta, tk;
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge mclk);
      ta = s_axi_arvalid & s_axi_arready;
      tk = s_axi_rvalid;
      rv = s_axi_rdata;
      rr = s_axi_rresp;
      @(posedge mclk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tk) s_axi_rready <= 1'b0;
    end while (!tk);
  endtask
  function automatic logic [31:0] dm(logic [15:0] c, logic sh);
    logic sup;
    sup = c[11:10] == 2'h3 && c[14:13] == 2'h3 && !c[0] &&
      (c[9:1] <= 9'h00B || (sh && c[9:1] <= 9'h00E));
    return {19'h0, c[9:1], sup, !c[0], c[14:13] == 2'h3, c[11:10] == 2'h3};
  endfunction
  function automatic int mdl(logic [8:0] q, logic [6:0] m);
    if (q[0]) return int'(nf);
    if (q[1] && m[0] && !bm[nv]) return 2;
    if (q[4]) return 3;
    if (q[5] && m[1]) return 4;
    if (q[6]) return m[2] ? 5 : 6;
    if ((q[1] && bm[nv]) || (q[2] && ctl[0])) return 0;
    if (q[3] && ctl[1]) return 1;
    if (q[7] && !m[6] && !m[5] && ctl[3]) return 8;
    if (q[7] && m[3] && !m[4] && !m[5] && ctl[2]) return 7;
    if (q[8]) return 9;
    return -1;
  endfunction
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  initial begin
    #1_000_000 bad_count++;
    finish_test();
  end
  initial begin
    {nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, p, l, nv, nf} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
    {s_axi_wdata, last, ctl, bm, lf} = '0;
    {ce, s_axi_wstrb} = 5'h1F;
    void'($urandom(32'h39316E55));
    repeat (20) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    #1 chk({exit_reason[31:1], field_supported}, 32'h1);
    for (int j = 0; j < 40; j++) begin
      e = (j < 17) ? 16'h6C00 + 16'(2 * j) : 16'($urandom);
      if (j[0]) e = (e | 16'h6C00) & 16'hFC1F;
      s = 1'($urandom);
      wr(`OFS_CONTROLS, {27'h0, s, 4'h0});
      wr(`OFS_FIELD_SELECT, {16'h0, e});
      rd(`OFS_DECODE_STATUS);
      xd = dm(e, s);
      chk(rv, xd);
      chk({field_supported, 4'(selected_field)},
        {xd[3], xd[3] ? xd[7:4] : 4'h0});
      wr(`OFS_FIELD_LOW, {16'h0, e});
      rd(`OFS_FIELD_LOW);
      chk(rv, xd[3] ? {16'h0, e} : 32'h0);
    end
    rd(8'h20);
    chk({30'h0, rr}, 32'h2);
    wr(8'h20, 32'h0);
    chk({30'h0, rr}, 32'h2);
    for (int k = 0; k < 4; k++) begin
      ctl = 4'($urandom);
      bm = $urandom;
      wr(`OFS_CONTROLS, {28'h0, ctl});
      wr(`OFS_EXC_BITMAP, bm);
      for (int n = 0; n < 60; n++) begin
        pn = 9'h1 << ($urandom % 9);
        if ($urandom % 4 == 0) pn |= 9'h1 << ($urandom % 9);
        nl = 7'($urandom);
        @(posedge mclk);
        p <= pn;
        l <= nl;
        nv <= 5'($urandom);
        nf <= 16'($urandom);
        #1 x = mdl(pn, nl);
        @(posedge mclk);
        p <= 9'h0;
        #1 chk({31'h0, exit_valid}, {31'h0, x >= 0});
        if (x >= 0) last = 32'(x);
        if (x >= 0) nr++;
        if (x >= 0) lf = pn[0];
        if (x >= 0) chk(exit_reason, last);
      end
    end
    @(posedge mclk);
    ce <= 1'b0;
    p <= 9'h10;
    @(posedge mclk);
    p <= 9'h0;
    ce <= 1'b1;
    #1 chk({31'h0, exit_valid}, 32'h0);
    rd(`OFS_EXIT_REASON);
    chk(rv, last);
    rd(`OFS_EXIT_STATUS);
    chk(rv, {16'(nr), 14'h0, lf, nr > 0});
    finish_test();
  end
endmodule
